//--- shared/opl_consts.svh
/*
 * constants of the operator panel lamp block: register byte addresses,
 * field positions, reset values, bus responses and blink timing.
 * assumes a 40 MHz system clock.
 */
`ifndef OPL_CONSTS_SVH
`define OPL_CONSTS_SVH

// register byte addresses
`define OPL_ADDR_CTRL       8'h00
`define OPL_ADDR_SRC        8'h04
`define OPL_ADDR_MINF       8'h08
`define OPL_ADDR_STAT       8'h0c
`define OPL_ADDR_ISR        8'h10
`define OPL_ADDR_IMR        8'h14

// field positions
`define OPL_CTRL_KEY_EN     0
`define OPL_SRC_RUN_LSB     0
`define OPL_SRC_REF_LSB     4
`define OPL_STAT_REMOTE     8
`define OPL_STAT_STOP_LATCH 9
`define OPL_IRQ_FAULT       0
`define OPL_IRQ_ALARM       1
`define OPL_IRQ_MODE        2

// reset values
`define OPL_CTRL_KEY_EN_RST 1'h1

// source selection codes
`define OPL_SEL_PANEL       3'h0
`define OPL_REF_SEL_MAX     3'h4

// bus responses
`define OPL_RESP_OKAY       2'h0
`define OPL_RESP_SLVERR     2'h2

// blink timing
`define OPL_CLK_HZ          40000000
`define OPL_BLINK_HALF_MS   250
`define OPL_BLINK_HALF_CYC  ((`OPL_CLK_HZ / 1000) * `OPL_BLINK_HALF_MS)

`endif

//--- shared/opl_pkg.sv
/*
 * types of the operator panel lamp block: drive status and lamp
 * carriers, and the state records of the two modules.
 * assumes opl_consts.svh for all numeric constants.
 */
package opl_pkg;

    typedef struct packed {
        logic        fwd_cmd;
        logic        rev_cmd;
        logic        running;
        logic        decel;
        logic        fault;
        logic        alarm;
        logic [15:0] freq_ref;
    } opl_drv_t;

    typedef struct packed {
        logic forward_lamp;
        logic reverse_lamp;
        logic command_source_lamp;
        logic reference_source_lamp;
        logic alarm_lamp;
        logic run_lamp;
        logic stop_lamp;
    } opl_lamps_t;

    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        aw_got;
        logic        w_got;
        logic [7:0]  awaddr;
        logic [31:0] wdata;
        logic [3:0]  wstrb;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        key_en;
        logic [1:0]  run_sel;
        logic [2:0]  ref_sel;
        logic [15:0] min_freq;
        logic [2:0]  isr;
        logic [2:0]  imr;
        logic        irq;
        logic        remote;
        logic        stop_latch;
        logic        fault_d;
        logic        alarm_d;
        logic        blink;
        opl_lamps_t  lamps;
    } opl_state_t;

    typedef struct packed {
        logic [23:0] cnt;
        logic        tick;
    } opl_div_t;

endpackage

//--- hw/opl_tick_div.sv
/*
 * clock divider giving a one-cycle enable pulse every PERIOD cycles.
 * assumes PERIOD of at least 2 and below 2**24.
 */
`timescale 1ns/1ps
`include "opl_consts.svh"

module opl_tick_div
    import opl_pkg::*;
#(
    parameter int unsigned PERIOD = `OPL_BLINK_HALF_CYC
) (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // enable pulse
    output logic      tick
);

    opl_div_t s_reg;
    opl_div_t s_next;

    always_comb begin
        s_next      = s_reg;
        s_next.tick = 1'b0;
        if (s_reg.cnt == 24'(PERIOD - 1)) begin
            s_next.cnt  = '0;
            s_next.tick = 1'b1;
        end else begin
            s_next.cnt = s_reg.cnt + 24'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick = s_reg.tick;

    a_tick_single: assert property (
        @(posedge aclk) disable iff (!aresetn) tick |=> !tick)
        else $error("divider tick lasted more than one cycle");

endmodule

//--- hw/opl_lamps.sv
/*
 * status lamp logic of the drive keypad panel with an axi4-lite
 * register slave and one level interrupt.
 * assumes drive status and key pulses come from logic on aclk.
 */
// Functional notes
// - forward lamp on exactly while a forward run command is present.
// - reverse lamp on exactly while a reverse run command is present.
// - alarm lamp steady on while a fault is active.
// - alarm lamp flashes while an alarm, not a fault, is active.
// - local operation holds command and reference source lamps off.
// - remote with terminal, serial or option run source lights command lamp.
// - remote with keypad run source keeps command source lamp off.
// - remote with terminal, serial, option or pulse reference lights ref lamp.
// - remote with keypad reference source keeps reference lamp off.
// - run lamp on while running, blinking while decelerating, off stopped.
// - stop lamp steady while decelerating or stopped, off while running.
// - stop lamp blinks on run command with reference below minimum.
// - stop lamp blinks running remote after panel stop key press.
// - mode key toggles local and remote unless key is disabled.
`timescale 1ns/1ps
`include "opl_consts.svh"

module opl_lamps
    import opl_pkg::*;
#(
    parameter int unsigned BLINK_HALF_CYCLES = `OPL_BLINK_HALF_CYC
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // drive status and panel keys
    input  wire opl_drv_t    drv_status,
    input  wire logic        mode_key_press,
    input  wire logic        stop_key_press,
    // axi4-lite write
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [7:0]  awaddr,
    input  wire logic        wvalid,
    output logic             wready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    output logic             bvalid,
    input  wire logic        bready,
    output logic [1:0]       bresp,
    // axi4-lite read
    input  wire logic        arvalid,
    output logic             arready,
    input  wire logic [7:0]  araddr,
    output logic             rvalid,
    input  wire logic        rready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    // lamps and interrupt
    output opl_lamps_t       lamps,
    output logic             irq
);

    localparam opl_state_t S_RST = '{
        key_en:  `OPL_CTRL_KEY_EN_RST,
        default: '0
    };

    opl_state_t s_reg;
    opl_state_t s_next;
    logic       blink_tick;

    opl_tick_div #(
        .PERIOD (BLINK_HALF_CYCLES)
    ) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .tick    (blink_tick)
    );

    function automatic logic [31:0] merge(input logic [31:0] cur,
                                          input logic [31:0] dat,
                                          input logic [3:0]  strb);
        logic [31:0] r;
        r = cur;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = dat[8*i +: 8];
            end
        end
        return r;
    endfunction

    logic run_cmd;
    logic low_ref;
    logic stop_blink;

    assign run_cmd    = drv_status.fwd_cmd | drv_status.rev_cmd;
    assign low_ref    = run_cmd && (drv_status.freq_ref < s_reg.min_freq);
    assign stop_blink = low_ref
                     || (s_reg.remote && drv_status.running
                         && s_reg.stop_latch);

    always_comb begin
        logic [31:0] w;
        logic [31:0] rd;
        logic [2:0]  clr;
        logic [2:0]  ev;
        logic [31:0] mf;
        w      = merge('0, s_reg.wdata, s_reg.wstrb);
        mf     = merge({16'h0, s_reg.min_freq}, s_reg.wdata, s_reg.wstrb);
        rd     = '0;
        clr    = '0;
        ev     = '0;
        s_next = s_reg;

        // write channel
        if (s_reg.awready && awvalid) begin
            s_next.aw_got = 1'b1;
            s_next.awaddr = awaddr;
        end
        if (s_reg.wready && wvalid) begin
            s_next.w_got = 1'b1;
            s_next.wdata = wdata;
            s_next.wstrb = wstrb;
        end
        if (s_reg.bvalid && bready) begin
            s_next.bvalid = 1'b0;
        end
        if (s_reg.aw_got && s_reg.w_got) begin
            s_next.aw_got = 1'b0;
            s_next.w_got  = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp  = `OPL_RESP_OKAY;
            case ({s_reg.awaddr[7:2], 2'b00})
                `OPL_ADDR_CTRL: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.key_en = w[`OPL_CTRL_KEY_EN];
                    end
                end
                `OPL_ADDR_SRC: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.run_sel = w[`OPL_SRC_RUN_LSB +: 2];
                        s_next.ref_sel = w[`OPL_SRC_REF_LSB +: 3];
                    end
                end
                `OPL_ADDR_MINF: begin
                    s_next.min_freq = mf[15:0];
                end
                `OPL_ADDR_STAT: begin
                end
                `OPL_ADDR_ISR: begin
                    clr = w[2:0];
                end
                `OPL_ADDR_IMR: begin
                    if (s_reg.wstrb[0]) begin
                        s_next.imr = w[2:0];
                    end
                end
                default: begin
                    s_next.bresp = `OPL_RESP_SLVERR;
                end
            endcase
        end
        s_next.awready = !s_next.aw_got && !s_next.bvalid;
        s_next.wready  = !s_next.w_got && !s_next.bvalid;

        // read channel
        case ({araddr[7:2], 2'b00})
            `OPL_ADDR_CTRL: rd[`OPL_CTRL_KEY_EN] = s_reg.key_en;
            `OPL_ADDR_SRC: begin
                rd[`OPL_SRC_RUN_LSB +: 2] = s_reg.run_sel;
                rd[`OPL_SRC_REF_LSB +: 3] = s_reg.ref_sel;
            end
            `OPL_ADDR_MINF: rd[15:0] = s_reg.min_freq;
            `OPL_ADDR_STAT: begin
                rd[6:0]                  = s_reg.lamps;
                rd[`OPL_STAT_REMOTE]     = s_reg.remote;
                rd[`OPL_STAT_STOP_LATCH] = s_reg.stop_latch;
            end
            `OPL_ADDR_ISR: rd[2:0] = s_reg.isr;
            `OPL_ADDR_IMR: rd[2:0] = s_reg.imr;
            default: rd = '0;
        endcase
        if (s_reg.rvalid && rready) begin
            s_next.rvalid = 1'b0;
        end
        if (s_reg.arready && arvalid) begin
            s_next.rvalid = 1'b1;
            s_next.rdata  = rd;
            case ({araddr[7:2], 2'b00})
                `OPL_ADDR_CTRL, `OPL_ADDR_SRC, `OPL_ADDR_MINF,
                `OPL_ADDR_STAT, `OPL_ADDR_ISR, `OPL_ADDR_IMR:
                    s_next.rresp = `OPL_RESP_OKAY;
                default: s_next.rresp = `OPL_RESP_SLVERR;
            endcase
        end
        s_next.arready = !s_next.rvalid;

        // shared blink toggle
        if (blink_tick) begin
            s_next.blink = !s_reg.blink;
        end

        // local and remote selection
        if (mode_key_press && s_reg.key_en) begin
            s_next.remote          = !s_reg.remote;
            ev[`OPL_IRQ_MODE]      = 1'b1;
        end

        // stop key latch while running remote
        if (!drv_status.running || !s_reg.remote) begin
            s_next.stop_latch = 1'b0;
        end else if (stop_key_press) begin
            s_next.stop_latch = 1'b1;
        end

        // lamps
        s_next.lamps.forward_lamp = drv_status.fwd_cmd;
        s_next.lamps.reverse_lamp = drv_status.rev_cmd;
        s_next.lamps.command_source_lamp = s_reg.remote
            && (s_reg.run_sel != 2'(`OPL_SEL_PANEL));
        s_next.lamps.reference_source_lamp = s_reg.remote
            && (s_reg.ref_sel != `OPL_SEL_PANEL)
            && (s_reg.ref_sel <= `OPL_REF_SEL_MAX);
        if (drv_status.fault) begin
            s_next.lamps.alarm_lamp = 1'b1;
        end else begin
            s_next.lamps.alarm_lamp = drv_status.alarm
                                   && s_reg.blink;
        end
        if (drv_status.decel) begin
            s_next.lamps.run_lamp = s_reg.blink;
        end else begin
            s_next.lamps.run_lamp = drv_status.running;
        end
        if (stop_blink) begin
            s_next.lamps.stop_lamp = s_reg.blink;
        end else begin
            s_next.lamps.stop_lamp = drv_status.decel
                                  || !drv_status.running;
        end

        // interrupt status, set beats clear
        ev[`OPL_IRQ_FAULT] = drv_status.fault && !s_reg.fault_d;
        ev[`OPL_IRQ_ALARM] = drv_status.alarm && !s_reg.alarm_d;
        s_next.fault_d     = drv_status.fault;
        s_next.alarm_d     = drv_status.alarm;
        s_next.isr         = (s_reg.isr & ~clr) | ev;
        s_next.irq         = |(s_next.isr & s_next.imr);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_reg <= S_RST;
        end else begin
            s_reg <= s_next;
        end
    end

    assign awready = s_reg.awready;
    assign wready  = s_reg.wready;
    assign bvalid  = s_reg.bvalid;
    assign bresp   = s_reg.bresp;
    assign arready = s_reg.arready;
    assign rvalid  = s_reg.rvalid;
    assign rdata   = s_reg.rdata;
    assign rresp   = s_reg.rresp;
    assign lamps   = s_reg.lamps;
    assign irq     = s_reg.irq;

    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_fwd_follow: assert property (
        1'b1 |=> lamps.forward_lamp == $past(drv_status.fwd_cmd))
        else $error("forward lamp does not follow command");
    a_rev_follow: assert property (
        1'b1 |=> lamps.reverse_lamp == $past(drv_status.rev_cmd))
        else $error("reverse lamp does not follow command");
    a_fault_steady: assert property (
        drv_status.fault |=> lamps.alarm_lamp)
        else $error("alarm lamp not steady on fault");
    a_alarm_flash: assert property (
        drv_status.alarm && !drv_status.fault
        |=> lamps.alarm_lamp == $past(s_reg.blink))
        else $error("alarm lamp not flashing with blink");
    a_local_dark: assert property (
        !s_reg.remote
        |=> !lamps.command_source_lamp && !lamps.reference_source_lamp)
        else $error("source lamp lit in local mode");
    a_cmd_source: assert property (
        s_reg.remote
        |=> lamps.command_source_lamp == ($past(s_reg.run_sel) != 2'h0))
        else $error("command source lamp wrong in remote");
    a_ref_source: assert property (
        s_reg.remote && s_reg.ref_sel inside {[3'h1:3'h4]}
        |=> lamps.reference_source_lamp)
        else $error("reference source lamp off for outside source");
    a_ref_panel: assert property (
        s_reg.ref_sel == 3'h0 |=> !lamps.reference_source_lamp)
        else $error("reference lamp lit for keypad source");
    a_run_lamp: assert property (
        !drv_status.decel |=> lamps.run_lamp == $past(drv_status.running))
        else $error("run lamp wrong outside deceleration");
    a_stop_steady: assert property (
        aresetn && !stop_blink
        |=> lamps.stop_lamp == !$past(drv_status.running
                                      && !drv_status.decel))
        else $error("stop lamp wrong without blink cause");
    a_stop_blink: assert property (
        low_ref ##1 low_ref |-> lamps.stop_lamp == $past(s_reg.blink))
        else $error("stop lamp not blinking on low reference");
    a_in_phase: assert property (
        drv_status.alarm && !drv_status.fault && drv_status.decel
        |=> lamps.alarm_lamp == lamps.run_lamp)
        else $error("alarm and run lamps blink out of phase");
    a_mode_toggle: assert property (
        mode_key_press && s_reg.key_en
        |=> s_reg.remote != $past(s_reg.remote))
        else $error("mode key press did not toggle mode");
    a_mode_locked: assert property (
        !(mode_key_press && s_reg.key_en) |=> $stable(s_reg.remote))
        else $error("mode changed without enabled key press");

    c_go_remote: cover property (
        !s_reg.remote ##1 s_reg.remote);
    c_low_ref: cover property (low_ref ##1 lamps.stop_lamp);
    c_stop_key: cover property (s_reg.stop_latch ##1 lamps.stop_lamp);
    c_irq: cover property (!irq ##1 irq);

endmodule

//--- test/opl_drv_model.sv
/*
 * behavioural drive sequencer: turns run requests, fault, alarm and
 * a frequency reference into the drive status word of the lamp block.
 * assumes requests change right after a rising edge of aclk.
 */
`timescale 1ns/1ps

module opl_drv_model
    import opl_pkg::*;
#(
    parameter int DECEL_CYC = 40
) (
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // requests from the bench
    input  wire logic        fwd_req,
    input  wire logic        rev_req,
    input  wire logic        flt,
    input  wire logic        alm,
    input  wire logic [15:0] freq,
    // drive status
    output opl_drv_t         drv
);
    int   left;
    logic run_q;

    // ramp down for DECEL_CYC cycles once both run requests drop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            run_q <= 1'b0;
            left  <= 0;
        end else begin
            run_q <= fwd_req | rev_req;
            if (fwd_req | rev_req)
                left <= 0;
            else if (run_q)
                left <= DECEL_CYC;
            else if (left > 0)
                left <= left - 1;
        end
    end

    always_comb begin
        drv.fwd_cmd  = fwd_req;
        drv.rev_cmd  = rev_req;
        drv.running  = run_q | (left > 0);
        drv.decel    = !run_q && (left > 0);
        drv.fault    = flt;
        drv.alarm    = alm;
        drv.freq_ref = freq;
    end
endmodule

//--- test/test_operator_panel_status_lamps.sv
/*
 * self-checking bench of the panel lamp block: axi4-lite tasks, lamp
 * pattern notes checked over a window by a monitor process.
 * assumes opl_drv_model as drive sequencer, 40 MHz clock.
 */
`timescale 1ns/1ps
`include "opl_consts.svh"

module test_operator_panel_status_lamps
    import opl_pkg::*;
;
    localparam logic [1:0] OF = 2'h0;
    localparam logic [1:0] ON = 2'h1;
    localparam logic [1:0] BL = 2'h2;
    localparam logic [1:0] DC = 2'h3;
    localparam int         LIMIT = 20000;

    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        mode_key = 1'b0, stop_key = 1'b0;
    logic        fwd_req = 1'b0, rev_req = 1'b0, flt = 1'b0, alm = 1'b0;
    logic [15:0] freq = 16'h0000;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, wd, rnd = 32'h00009a58;
    logic [3:0]  wstrb = 4'hf;
    logic        awready, wready, bvalid, arready, rvalid, irq, chk_go;
    logic [1:0]  bresp, rresp, g;
    logic [31:0] rdata;
    opl_drv_t    drv;
    opl_lamps_t  lamps;
    logic [1:0]  bq[$];
    logic [33:0] rq[$];
    logic [14:0] lq[$], ln;
    logic [6:0]  s1, s0, bm, bv;
    logic        ph;
    int          errors = 0, check_count = 0, cyc = 0, i, j, k;

    opl_drv_model #(.DECEL_CYC(40)) model (.aclk(aclk), .aresetn(aresetn),
        .fwd_req(fwd_req), .rev_req(rev_req), .flt(flt), .alm(alm),
        .freq(freq), .drv(drv));

    opl_lamps #(.BLINK_HALF_CYCLES(4)) dut (.aclk(aclk), .aresetn(aresetn),
        .drv_status(drv), .mode_key_press(mode_key),
        .stop_key_press(stop_key), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .lamps(lamps), .irq(irq));

    always #12.5 aclk = ~aclk;

    function automatic logic [31:0] xs(input logic [31:0] v);
        logic [31:0] x;
        x = v ^ (v << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    task automatic fail(input string m);
        errors++;
        $display("[FAIL] %0t %s", $time, m);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        logic aw_d, w_d;
        bq.push_back(r);
        aw_d = 1'b0;
        w_d = 1'b0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready && !aw_d) begin
                aw_d = 1'b1;
                awvalid <= 1'b0;
            end
            if (wready && !w_d) begin
                w_d = 1'b1;
                wvalid <= 1'b0;
            end
        end while (!(aw_d && w_d));
        while (!bvalid)
            @(posedge aclk);
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] r);
        rq.push_back({d, r});
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do
            @(posedge aclk);
        while (!arready);
        arvalid <= 1'b0;
        while (!rvalid)
            @(posedge aclk);
        rready <= 1'b0;
    endtask

    task automatic press(input bit stop);
        @(posedge aclk);
        if (stop)
            stop_key <= 1'b1;
        else
            mode_key <= 1'b1;
        @(posedge aclk);
        stop_key <= 1'b0;
        mode_key <= 1'b0;
    endtask

    // lamp codes fwd, rev, cmd, ref, alarm, run, stop; then irq
    task automatic ex(input logic [13:0] c, input logic q);
        repeat (2) @(posedge aclk);
        lq.push_back({q, c});
        chk_go <= 1'b1;
        @(posedge aclk);
        chk_go <= 1'b0;
        repeat (26) @(posedge aclk);
    endtask

    always @(posedge aclk) begin
        if (bvalid && bready) begin
            check_count++;
            if (bresp !== bq.pop_front())
                fail("write response differs");
        end
        if (rvalid && rready) begin
            check_count++;
            if ({rdata, rresp} !== rq.pop_front())
                fail("read data or response differs");
        end
    end

    // watch lamps for 24 cycles per note; blinking lamps share one phase
    always begin
        @(posedge aclk);
        if (chk_go === 1'b1) begin
            ln = lq.pop_front();
            check_count++;
            if (irq !== ln[14])
                fail("interrupt level differs");
            s1 = '0;
            s0 = '0;
            ph = 1'b1;
            for (k = 0; k < 7; k++)
                bm[k] = (ln[2*k+:2] == BL);
            for (k = 0; k < 24; k++) begin
                @(posedge aclk);
                s1 = s1 | lamps;
                s0 = s0 | ~lamps;
                bv = lamps & bm;
                ph = ph & ((bv === 7'h00) || (bv === bm));
            end
            if (!ph)
                fail("blinking lamps out of phase");
            for (k = 0; k < 7; k++) begin
                g = (s1[k] === 1'b1) ? ((s0[k] === 1'b1) ? BL : ON) : OF;
                if (ln[2*k+:2] != DC && g !== ln[2*k+:2])
                    fail("lamp pattern differs");
            end
        end
    end

    always @(posedge aclk) begin
        cyc++;
        if (cyc == LIMIT) begin
            fail("timeout");
            tally_and_finish();
        end
    end

    initial begin
        chk_go = 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        axi_rd(`OPL_ADDR_CTRL, 32'h1, `OPL_RESP_OKAY);
        axi_rd(`OPL_ADDR_SRC, 32'h0, `OPL_RESP_OKAY);
        axi_rd(8'h18, 32'h0, `OPL_RESP_SLVERR);
        axi_wr(8'h18, 32'hffffffff, `OPL_RESP_SLVERR);
        axi_wr(`OPL_ADDR_STAT, 32'hffffffff, `OPL_RESP_OKAY);
        axi_rd(`OPL_ADDR_STAT, 32'h1, `OPL_RESP_OKAY);
        $display("test registers done");
        axi_wr(`OPL_ADDR_SRC, 32'h11, `OPL_RESP_OKAY);
        ex({OF, OF, OF, OF, OF, OF, ON}, 1'b0);
        press(1'b0);
        axi_rd(`OPL_ADDR_ISR, 32'h4, `OPL_RESP_OKAY);
        axi_wr(`OPL_ADDR_ISR, 32'h4, `OPL_RESP_OKAY);
        // codes 5, 0..4; an undefined reference code keeps the lamp dark
        for (i = 0; i < 6; i++) begin
            j = (i + 5) % 6;
            wd = 32'h0;
            wd[6:4] = j[2:0];
            wd[1:0] = j[1:0];
            axi_wr(`OPL_ADDR_SRC, wd, `OPL_RESP_OKAY);
            ex({OF, OF, (j % 4 != 0) ? ON : OF, (j != 0 && j < 5) ? ON : OF,
                OF, OF, ON}, 1'b0);
        end
        axi_wr(`OPL_ADDR_CTRL, 32'h0, `OPL_RESP_OKAY);
        press(1'b0);
        ex({OF, OF, OF, ON, OF, OF, ON}, 1'b0);
        axi_wr(`OPL_ADDR_CTRL, 32'h1, `OPL_RESP_OKAY);
        $display("test sources done");
        axi_wr(`OPL_ADDR_MINF, 32'h8000, `OPL_RESP_OKAY);
        rnd = xs(rnd);
        fwd_req <= 1'b1;
        freq <= {1'b1, rnd[14:0]};
        ex({ON, OF, OF, ON, OF, ON, OF}, 1'b0);
        press(1'b1);
        ex({ON, OF, OF, ON, OF, ON, BL}, 1'b0);
        press(1'b0);
        ex({ON, OF, OF, OF, OF, ON, OF}, 1'b0);
        press(1'b0);
        rnd = xs(rnd);
        freq <= {1'b0, rnd[14:0]};
        ex({ON, OF, OF, ON, OF, ON, BL}, 1'b0);
        rnd = xs(rnd);
        fwd_req <= 1'b0;
        rev_req <= 1'b1;
        freq <= {1'b1, rnd[14:0]};
        ex({OF, ON, OF, ON, OF, ON, OF}, 1'b0);
        rev_req <= 1'b0;
        alm <= 1'b1;
        ex({OF, OF, OF, ON, BL, BL, ON}, 1'b0);
        repeat (20) @(posedge aclk);
        ex({OF, OF, OF, ON, BL, OF, ON}, 1'b0);
        $display("test run states done");
        axi_wr(`OPL_ADDR_ISR, 32'h7, `OPL_RESP_OKAY);
        axi_wr(`OPL_ADDR_IMR, 32'h1, `OPL_RESP_OKAY);
        ex({OF, OF, OF, ON, BL, OF, ON}, 1'b0);
        flt <= 1'b1;
        ex({OF, OF, OF, ON, ON, OF, ON}, 1'b1);
        axi_rd(`OPL_ADDR_ISR, 32'h1, `OPL_RESP_OKAY);
        axi_wr(`OPL_ADDR_ISR, 32'h1, `OPL_RESP_OKAY);
        ex({OF, OF, OF, ON, ON, OF, ON}, 1'b0);
        $display("test alarm done");
        tally_and_finish();
    end
endmodule
